/* File: verilog/stl_pkg.sv */
/*
 * Constants for the health-monitoring subcommand responder:
 * subcommand codes, signatures, sector layout and state encodings.
 * Assumes a task-file front end that decodes the health command.
 */
package stl_pkg;

	// ----------------------------------------------------------------
	// Subcommand codes and signatures
	// ----------------------------------------------------------------
	localparam logic [7:0] STL_SUB_RD_THR = 8'hd1;
	localparam logic [7:0] STL_SUB_RET_STATUS = 8'hda;
	localparam logic [7:0] STL_SUB_RD_LOG = 8'hd5;
	localparam logic [7:0] STL_SUB_WR_LOG = 8'hd6;
	localparam logic [7:0] STL_SIG_LO = 8'h4f;
	localparam logic [7:0] STL_SIG_HI = 8'hc2;
	localparam logic [7:0] STL_BAD_LO = 8'hf4;
	localparam logic [7:0] STL_BAD_HI = 8'h2c;

	// ----------------------------------------------------------------
	// Log addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] STL_LOG_DIR = 8'h00;
	localparam logic [7:0] STL_LOG_VEND_FIRST = 8'h80;
	localparam logic [7:0] STL_LOG_VEND_LAST = 8'h9f;
	localparam logic [7:0] STL_LOG_RSV0 = 8'ha0;
	localparam logic [7:0] STL_LOG_RSV1 = 8'ha1;
	localparam logic [7:0] STL_LOG_RSV2 = 8'ha2;

	// ----------------------------------------------------------------
	// Sector layout
	// ----------------------------------------------------------------
	localparam logic [8:0] STL_LAST_IDX = 9'h1ff;
	localparam logic [7:0] STL_THR_VER_LO = 8'h10;
	localparam logic [8:0] STL_ENT_FIRST = 9'h002;
	localparam logic [8:0] STL_ENT_END = 9'h16a;
	localparam logic [8:0] STL_ENT_LEN = 9'h00c;
	localparam logic [7:0] STL_DIR_VER = 8'h01;
	localparam logic [8:0] STL_DIR_FEAT_IDX = 9'h00a;
	localparam logic [7:0] STL_DIR_FEAT_CNT = 8'h01;
	localparam logic [8:0] STL_DIR_VEND_FIRST = 9'h100;
	localparam logic [8:0] STL_DIR_VEND_LAST = 9'h13f;
	localparam logic [7:0] STL_DIR_VEND_CNT = 8'h10;
	localparam logic [8:0] STL_DIR_RSV0_IDX = 9'h140;
	localparam logic [7:0] STL_DIR_RSV0_CNT = 8'h04;
	localparam logic [8:0] STL_DIR_RSV1_IDX = 9'h142;
	localparam logic [8:0] STL_DIR_RSV2_IDX = 9'h144;
	localparam logic [7:0] STL_DIR_RSV_CNT = 8'h01;

	// Attribute identifiers in entry order; entries 13 to 29 are empty
	localparam logic [7:0] STL_ID_SPARE = 8'hc4;
	localparam logic [7:0] STL_ID_ERASE = 8'he5;
	localparam int STL_NUM_IDS = 13;
	localparam logic [7:0] STL_IDS [STL_NUM_IDS] = '{
		8'hc4, 8'hd5, 8'he5, 8'hcb, 8'hcc, 8'hc7, 8'he8,
		8'h0c, 8'hf1, 8'hf2, 8'hd6, 8'hd7, 8'hc2};

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		STL_ST_IDLE = 2'b00,
		STL_ST_READ = 2'b01,
		STL_ST_WRITE = 2'b10
	} stl_state_t;

	typedef enum logic [1:0] {
		STL_SEC_THR = 2'b00,
		STL_SEC_DIR = 2'b01,
		STL_SEC_ZERO = 2'b10
	} stl_sector_t;

	localparam logic [7:0] STL_ZERO_B = 8'h00;
	localparam logic [8:0] STL_IDX_RST = 9'h000;
endpackage

/* File: verilog/stl_sector_gen.sv */
/*
 * Byte generator for the threshold and log-directory sectors.
 * Purely combinational; the caller registers the byte and adds the checksum.
 */
`timescale 1ns/1ps
module stl_sector_gen
	import stl_pkg::*;
(
	// Selection
	input wire stl_sector_t kind_i,
	input wire logic [8:0] idx_i,
	// Format-time thresholds
	input wire logic [7:0] spare_thr_i,
	input wire logic [7:0] erase_thr_i,
	// Byte
	output logic [7:0] byte_o
);
	logic [8:0] rel;
	logic [8:0] ent;
	logic [8:0] off;

	always_comb begin
		rel = idx_i - STL_ENT_FIRST;
		ent = rel / STL_ENT_LEN;
		off = rel % STL_ENT_LEN;
		byte_o = STL_ZERO_B;
		case (kind_i)
			STL_SEC_THR: begin
				if (idx_i == 9'h000) begin
					byte_o = STL_THR_VER_LO;
				end else if (idx_i >= STL_ENT_FIRST && idx_i < STL_ENT_END &&
					ent < 9'(STL_NUM_IDS)) begin
					if (off == 9'h000) begin
						byte_o = STL_IDS[ent[3:0]];
					end else if (off == 9'h001 && STL_IDS[ent[3:0]] == STL_ID_SPARE) begin
						byte_o = spare_thr_i;
					end else if (off == 9'h001 && STL_IDS[ent[3:0]] == STL_ID_ERASE) begin
						byte_o = erase_thr_i;
					end
				end
			end
			STL_SEC_DIR: begin
				// Every unassigned directory byte stays zero
				if (idx_i == 9'h000) begin
					byte_o = STL_DIR_VER;
				end else if (idx_i == STL_DIR_FEAT_IDX) begin
					byte_o = STL_DIR_FEAT_CNT;
				end else if (idx_i >= STL_DIR_VEND_FIRST && idx_i <= STL_DIR_VEND_LAST &&
					!idx_i[0]) begin
					byte_o = STL_DIR_VEND_CNT;
				end else if (idx_i == STL_DIR_RSV0_IDX) begin
					byte_o = STL_DIR_RSV0_CNT;
				end else if (idx_i == STL_DIR_RSV1_IDX || idx_i == STL_DIR_RSV2_IDX) begin
					byte_o = STL_DIR_RSV_CNT;
				end
			end
			default: begin
				byte_o = STL_ZERO_B;
			end
		endcase
	end
endmodule

/* File: verilog/stl_responder.sv */
/*
 * Health-monitoring subcommand responder: threshold sector, health
 * verdict, log directory, log reads and log write permission.
 * Assumes the task-file front end and the threshold flags run on core_clk_i.
 */
`timescale 1ns/1ps
// Operation
// - Act only with signature 4Fh/C2h loaded.
// - Read-thresholds sends exactly one 512-byte sector.
// - Version 0010h, 30 entries, zeros, checksum.
// - Spare and erase entries carry format thresholds.
// - Other entries: identifier then eleven zeros.
// - Exceeded threshold returns F4h/2Ch in cylinders.
// - Healthy leaves 4Fh/C2h in cylinder registers.
// - Recognise directory, vendor and reserved log addresses.
// - Directory: version 1, feature log one sector.
// - Vendor logs report sixteen sectors each.
// - Reserved logs report four, one, one sectors.
// - Unassigned directory bytes read as zero.
// - Write-log accepts vendor-specific addresses only.
module stl_responder
	import stl_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Subcommand request
	input wire logic cmd_valid_i,
	input wire logic [7:0] subcmd_i,
	input wire logic [7:0] cyl_lo_i,
	input wire logic [7:0] cyl_hi_i,
	input wire logic [7:0] log_addr_i,
	// Health inputs
	input wire logic [7:0] spare_thr_i,
	input wire logic [7:0] erase_thr_i,
	input wire logic spare_exceeded_i,
	input wire logic erase_exceeded_i,
	// Completion
	output logic done_o,
	output logic err_o,
	output logic [7:0] cyl_lo_o,
	output logic [7:0] cyl_hi_o,
	// Sector read stream
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	output logic rd_last_o,
	input wire logic rd_ready_i,
	// Sector write stream
	input wire logic [7:0] wr_data_i,
	input wire logic wr_valid_i,
	output logic wr_ready_o,
	// Log storage write port
	output logic log_wr_en_o,
	output logic [7:0] log_wr_log_o,
	output logic [8:0] log_wr_idx_o,
	output logic [7:0] log_wr_byte_o
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	stl_state_t state_q, state_d;
	stl_sector_t kind_q, kind_d;
	logic [8:0] idx_q, idx_d;
	logic [7:0] sum_q, sum_d;
	logic done_q, done_d, err_q, err_d;
	logic [7:0] cyl_lo_q, cyl_lo_d, cyl_hi_q, cyl_hi_d;
	logic [7:0] rd_data_q, rd_data_d;
	logic rd_valid_q, rd_valid_d, rd_last_q, rd_last_d;
	logic wr_ready_q, wr_ready_d;
	logic log_wr_en_q, log_wr_en_d;
	logic [7:0] log_q, log_d;
	logic [8:0] log_idx_q, log_idx_d;
	logic [7:0] log_byte_q, log_byte_d;
	logic [7:0] gen_byte;
	logic sig_ok, is_vend, is_rsv;

	stl_sector_gen u_gen (
		.kind_i(kind_q),
		.idx_i(idx_q),
		.spare_thr_i(spare_thr_i),
		.erase_thr_i(erase_thr_i),
		.byte_o(gen_byte)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		sig_ok = (cyl_lo_i == STL_SIG_LO) && (cyl_hi_i == STL_SIG_HI);
		is_vend = (log_addr_i >= STL_LOG_VEND_FIRST) && (log_addr_i <= STL_LOG_VEND_LAST);
		is_rsv = (log_addr_i == STL_LOG_RSV0) || (log_addr_i == STL_LOG_RSV1) ||
			(log_addr_i == STL_LOG_RSV2);
		state_d = state_q;
		kind_d = kind_q;
		idx_d = idx_q;
		sum_d = sum_q;
		done_d = 1'b0;
		err_d = 1'b0;
		cyl_lo_d = cyl_lo_q;
		cyl_hi_d = cyl_hi_q;
		rd_data_d = rd_data_q;
		rd_valid_d = rd_valid_q;
		rd_last_d = rd_last_q;
		wr_ready_d = wr_ready_q;
		log_wr_en_d = 1'b0;
		log_d = log_q;
		log_idx_d = log_idx_q;
		log_byte_d = log_byte_q;
		case (state_q)
			STL_ST_IDLE: begin
				if (cmd_valid_i) begin
					idx_d = STL_IDX_RST;
					sum_d = STL_ZERO_B;
					cyl_lo_d = cyl_lo_i;
					cyl_hi_d = cyl_hi_i;
					if (!sig_ok) begin
						err_d = 1'b1;
					end else if (subcmd_i == STL_SUB_RET_STATUS) begin
						done_d = 1'b1;
						if (spare_exceeded_i || erase_exceeded_i) begin
							cyl_lo_d = STL_BAD_LO;
							cyl_hi_d = STL_BAD_HI;
						end else begin
							cyl_lo_d = STL_SIG_LO;
							cyl_hi_d = STL_SIG_HI;
						end
					end else if (subcmd_i == STL_SUB_RD_THR) begin
						kind_d = STL_SEC_THR;
						state_d = STL_ST_READ;
					end else if (subcmd_i == STL_SUB_RD_LOG) begin
						// Log bodies are outside this block, so they read as zeros
						if (log_addr_i == STL_LOG_DIR) begin
							kind_d = STL_SEC_DIR;
							state_d = STL_ST_READ;
						end else if (is_vend || is_rsv) begin
							kind_d = STL_SEC_ZERO;
							state_d = STL_ST_READ;
						end else begin
							err_d = 1'b1;
						end
					end else if (subcmd_i == STL_SUB_WR_LOG) begin
						if (is_vend) begin
							log_d = log_addr_i;
							wr_ready_d = 1'b1;
							state_d = STL_ST_WRITE;
						end else begin
							err_d = 1'b1;
						end
					end else begin
						err_d = 1'b1;
					end
				end
			end
			STL_ST_READ: begin
				if (!rd_valid_q || rd_ready_i) begin
					if (rd_valid_q && rd_last_q) begin
						rd_valid_d = 1'b0;
						rd_last_d = 1'b0;
						done_d = 1'b1;
						state_d = STL_ST_IDLE;
					end else begin
						if (kind_q == STL_SEC_THR && idx_q == STL_LAST_IDX) begin
							rd_data_d = 8'h00 - sum_q;
						end else begin
							rd_data_d = gen_byte;
						end
						sum_d = sum_q + rd_data_d;
						rd_valid_d = 1'b1;
						rd_last_d = (idx_q == STL_LAST_IDX);
						idx_d = idx_q + 9'h001;
					end
				end
			end
			STL_ST_WRITE: begin
				if (wr_valid_i && wr_ready_q) begin
					log_wr_en_d = 1'b1;
					log_idx_d = idx_q;
					log_byte_d = wr_data_i;
					idx_d = idx_q + 9'h001;
					if (idx_q == STL_LAST_IDX) begin
						wr_ready_d = 1'b0;
						done_d = 1'b1;
						state_d = STL_ST_IDLE;
					end
				end
			end
			default: begin
				state_d = STL_ST_IDLE;
				rd_valid_d = 1'b0;
				wr_ready_d = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state_q <= STL_ST_IDLE;
			kind_q <= STL_SEC_THR;
			idx_q <= STL_IDX_RST;
			sum_q <= STL_ZERO_B;
			done_q <= 1'b0;
			err_q <= 1'b0;
			cyl_lo_q <= STL_ZERO_B;
			cyl_hi_q <= STL_ZERO_B;
			rd_data_q <= STL_ZERO_B;
			rd_valid_q <= 1'b0;
			rd_last_q <= 1'b0;
			wr_ready_q <= 1'b0;
			log_wr_en_q <= 1'b0;
			log_q <= STL_ZERO_B;
			log_idx_q <= STL_IDX_RST;
			log_byte_q <= STL_ZERO_B;
		end else begin
			state_q <= state_d;
			kind_q <= kind_d;
			idx_q <= idx_d;
			sum_q <= sum_d;
			done_q <= done_d;
			err_q <= err_d;
			cyl_lo_q <= cyl_lo_d;
			cyl_hi_q <= cyl_hi_d;
			rd_data_q <= rd_data_d;
			rd_valid_q <= rd_valid_d;
			rd_last_q <= rd_last_d;
			wr_ready_q <= wr_ready_d;
			log_wr_en_q <= log_wr_en_d;
			log_q <= log_d;
			log_idx_q <= log_idx_d;
			log_byte_q <= log_byte_d;
		end
	end

	assign done_o = done_q;
	assign err_o = err_q;
	assign cyl_lo_o = cyl_lo_q;
	assign cyl_hi_o = cyl_hi_q;
	assign rd_data_o = rd_data_q;
	assign rd_valid_o = rd_valid_q;
	assign rd_last_o = rd_last_q;
	assign wr_ready_o = wr_ready_q;
	assign log_wr_en_o = log_wr_en_q;
	assign log_wr_log_o = log_q;
	assign log_wr_idx_o = log_idx_q;
	assign log_wr_byte_o = log_byte_q;
endmodule

/* File: test/stl_responder_checker.sv */
/* Port assertions for the health subcommand responder.
 * Assumes it is bound to stl_responder on one clock. */
`timescale 1ns/1ps
module stl_responder_checker
	import stl_pkg::*;
(
	// Request side
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic cmd_valid_i,
	input wire logic [7:0] subcmd_i,
	input wire logic [7:0] cyl_lo_i,
	input wire logic [7:0] cyl_hi_i,
	input wire logic [7:0] log_addr_i,
	input wire logic spare_exceeded_i,
	input wire logic erase_exceeded_i,
	// Answer side
	input wire logic done_o,
	input wire logic err_o,
	input wire logic [7:0] cyl_lo_o,
	input wire logic [7:0] cyl_hi_o,
	input wire logic rd_valid_o,
	input wire logic rd_last_o,
	input wire logic rd_ready_i,
	input wire logic [7:0] wr_data_i,
	input wire logic wr_valid_i,
	input wire logic wr_ready_o,
	input wire logic log_wr_en_o,
	input wire logic [7:0] log_wr_byte_o
);
	logic busy_q, busy_d;
	logic [8:0] beat_q, beat_d;
	// Busy ends with the completion pulse, so a request there is taken
	wire logic tk = cmd_valid_i && (!busy_q || done_o || err_o);
	wire logic sok = cyl_lo_i == STL_SIG_LO && cyl_hi_i == STL_SIG_HI;
	wire logic vend = log_addr_i >= STL_LOG_VEND_FIRST && log_addr_i <= STL_LOG_VEND_LAST;
	wire logic known = vend || log_addr_i == STL_LOG_DIR
		|| (log_addr_i >= STL_LOG_RSV0 && log_addr_i <= STL_LOG_RSV2);
	wire logic ok = tk && sok;
	wire logic hot = spare_exceeded_i || erase_exceeded_i;
	always_comb begin
		busy_d = tk ? 1'b1 : (done_o || err_o) ? 1'b0 : busy_q;
		beat_d = tk ? 9'h000 : beat_q + 9'(rd_valid_o && rd_ready_i);
		if (rst_i) begin
			busy_d = 1'b0;
			beat_d = 9'h000;
		end
	end
	always_ff @(posedge core_clk_i) begin
		busy_q <= busy_d;
		beat_q <= beat_d;
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	chk_sig_refused: assert property (
		tk && !sok |=> err_o && !done_o && cyl_lo_o == $past(cyl_lo_i)
		&& cyl_hi_o == $past(cyl_hi_i)) else $error("missing signature not aborted");
	chk_bad_health: assert property (
		ok && subcmd_i == STL_SUB_RET_STATUS && hot
		|=> done_o && cyl_lo_o == STL_BAD_LO && cyl_hi_o == STL_BAD_HI) else $error("bad verdict");
	chk_healthy_sig: assert property (
		ok && subcmd_i == STL_SUB_RET_STATUS && !hot
		|-> ##1 done_o && cyl_lo_o == STL_SIG_LO && cyl_hi_o == STL_SIG_HI) else $error("good verdict");
	chk_wr_refused: assert property (
		ok && subcmd_i == STL_SUB_WR_LOG && !vend |=> err_o ##1 !log_wr_en_o [*4])
		else $error("write to protected log");
	chk_log_addr: assert property (
		ok && subcmd_i == STL_SUB_RD_LOG |=> err_o == !$past(known)) else $error("log address decode");
	chk_last_beat: assert property (
		rd_valid_o && rd_ready_i |-> rd_last_o == (beat_q == STL_LAST_IDX)) else $error("last marker");
	chk_read_done: assert property (
		rd_valid_o && rd_ready_i && rd_last_o |=> done_o && !rd_valid_o) else $error("read end");
	chk_write_store: assert property (
		wr_valid_i && wr_ready_o |=> log_wr_en_o && log_wr_byte_o == $past(wr_data_i))
		else $error("write byte lost");
	chk_wr_open: assert property (
		ok && subcmd_i == STL_SUB_WR_LOG && vend |=> wr_ready_o && !err_o)
		else $error("write window not opened");
	chk_wr_close: assert property (
		done_o |-> !wr_ready_o) else $error("write window left open");
	cover property (done_o && cyl_lo_o == STL_BAD_LO);
	cover property (rd_valid_o && rd_ready_i && rd_last_o);
	cover property (log_wr_en_o && done_o);
endmodule
bind stl_responder stl_responder_checker i_chk (.core_clk_i, .rst_i, .cmd_valid_i, .subcmd_i,
	.cyl_lo_i, .cyl_hi_i, .log_addr_i, .spare_exceeded_i, .erase_exceeded_i, .done_o, .err_o,
	.cyl_lo_o, .cyl_hi_o, .rd_valid_o, .rd_last_o, .rd_ready_i, .wr_data_i, .wr_valid_i,
	.wr_ready_o, .log_wr_en_o, .log_wr_byte_o);

/* File: test/stl_host_model.sv */
/* Host side of the sector streams: a stalling read sink and a write source.
 * Assumes go_i is driven by non-blocking assignment at the falling edge. */
`timescale 1ns/1ps
module stl_host_model (
	// Control
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic wr_ready_i,
	// Streams
	output logic rd_ready_o,
	output logic wr_valid_o,
	output logic [7:0] wr_data_o
);
	logic took = 1'b0;
	int cnt = 0;
	initial begin
		rd_ready_o = 1'b0;
		wr_valid_o = 1'b0;
		wr_data_o = 8'h00;
	end
	always @(posedge clk_i) took = wr_valid_o && wr_ready_i;
	always @(negedge clk_i) begin
		rd_ready_o <= ($urandom % 4) != 0;
		if (took)
			cnt++;
		if (!go_i)
			cnt = 0;
		// An offer stays put until taken; idle data keeps moving
		if (wr_valid_o && !took) begin
		end else if (go_i && cnt < 512 && ($urandom % 3) != 0) begin
			wr_valid_o <= 1'b1;
			wr_data_o <= 8'(cnt) ^ 8'ha5;
		end else begin
			wr_valid_o <= 1'b0;
			wr_data_o <= ~wr_data_o;
		end
	end
endmodule

/* File: test/smart_threshold_log_responder_bench.sv */
/* Self-checking bench for the health subcommand responder.
 * Assumes stl_pkg, the responder, its bound checker and the host model. */
`timescale 1ns/1ps
module smart_threshold_log_responder_bench;
	import stl_pkg::*;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cmd_valid_i = 1'b0;
	logic spare_exceeded_i = 1'b0;
	logic erase_exceeded_i = 1'b0;
	logic wr_go = 1'b0;
	logic [7:0] subcmd_i = 8'h00, cyl_lo_i = 8'h00, cyl_hi_i = 8'h00, log_addr_i = 8'h00;
	logic [7:0] spare_thr_i = 8'h00, erase_thr_i = 8'h00;
	logic done_o, err_o, rd_valid_o, rd_last_o, rd_ready_i, wr_valid_i, wr_ready_o, log_wr_en_o;
	logic [7:0] cyl_lo_o, cyl_hi_o, rd_data_o, wr_data_i, log_wr_log_o, log_wr_byte_o, wlog;
	logic [8:0] log_wr_idx_o;
	logic [9:0] widx;
	logic [17:0] note;
	logic [8:0] rd_q[$];
	logic [17:0] st_q[$];
	logic [7:0] sec[512];
	int err_total = 0;
	int checked = 0;
	always #2 core_clk_i = ~core_clk_i;
	stl_responder i_dut (.core_clk_i, .rst_i, .cmd_valid_i, .subcmd_i, .cyl_lo_i, .cyl_hi_i,
		.log_addr_i, .spare_thr_i, .erase_thr_i, .spare_exceeded_i, .erase_exceeded_i, .done_o,
		.err_o, .cyl_lo_o, .cyl_hi_o, .rd_data_o, .rd_valid_o, .rd_last_o, .rd_ready_i,
		.wr_data_i, .wr_valid_i, .wr_ready_o, .log_wr_en_o, .log_wr_log_o, .log_wr_idx_o,
		.log_wr_byte_o);
	stl_host_model i_host (.clk_i(core_clk_i), .go_i(wr_go), .wr_ready_i(wr_ready_o),
		.rd_ready_o(rd_ready_i), .wr_valid_o(wr_valid_i), .wr_data_o(wr_data_i));
	task automatic chk(string what, logic [24:0] exp, logic [24:0] got);
		checked++;
		if (exp !== got) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Monitor: each completion or abort takes the oldest note
	// ----------------------------------------------------------------
	always @(posedge core_clk_i) begin
		if (!rst_i && rd_valid_o && rd_ready_i) begin
			if (rd_q.size() == 0)
				chk("read surplus", 25'h0, 25'h1);
			else
				chk("rd", 25'(rd_q.pop_front()), 25'({rd_last_o, rd_data_o}));
		end
		if (!rst_i && log_wr_en_o) begin
			chk("log wr", {wlog, widx[8:0], widx[7:0] ^ 8'ha5},
				{log_wr_log_o, log_wr_idx_o, log_wr_byte_o});
			widx <= widx + 10'h001;
		end
		if (!rst_i && (done_o !== 1'b0 || err_o !== 1'b0)) begin
			note = st_q.size() > 0 ? st_q.pop_front() : 18'h3ffff;
			chk("status", {6'h0, note[17:16], ~note[16], note[15:0] & {16{note[17]}}},
				{6'h0, note[17], err_o, done_o, {cyl_lo_o, cyl_hi_o} & {16{note[17]}}});
		end
	end
	// Note bits: 17 cylinder values matter, 16 abort expected
	task automatic cmd(logic [7:0] sc, logic [7:0] lo, logic [7:0] hi, logic [7:0] la,
		logic [17:0] n);
		int k;
		@(negedge core_clk_i);
		subcmd_i = sc;
		cyl_lo_i = lo;
		cyl_hi_i = hi;
		log_addr_i = la;
		cmd_valid_i = 1'b1;
		st_q.push_back(n);
		@(negedge core_clk_i);
		cmd_valid_i = 1'b0;
		for (k = 0; k < 3000 && done_o !== 1'b1 && err_o !== 1'b1; k++)
			@(negedge core_clk_i);
		if (k == 3000) begin
			chk("completion", 25'h1, 25'h0);
			print_verdict;
		end
	endtask
	task automatic send(logic [7:0] sc, logic [7:0] la);
		foreach (sec[i])
			rd_q.push_back({i == 511, sec[i]});
		cmd(sc, STL_SIG_LO, STL_SIG_HI, la, 18'h0);
		chk("bytes left", 25'h0, 25'(rd_q.size()));
	endtask
	initial begin
		logic [7:0] s;
		logic [7:0] subs[4];
		subs = '{STL_SUB_RD_THR, STL_SUB_RET_STATUS, STL_SUB_RD_LOG, STL_SUB_WR_LOG};
		s = 8'($urandom(32'hcb576a87));
		repeat (12) @(negedge core_clk_i);
		rst_i = 1'b0;
		for (int i = 0; i < 4; i++) begin
			{spare_exceeded_i, erase_exceeded_i} = 2'(i);
			cmd(STL_SUB_RET_STATUS, STL_SIG_LO, STL_SIG_HI, 8'h00, i == 0 ?
				{2'b10, STL_SIG_LO, STL_SIG_HI} : {2'b10, STL_BAD_LO, STL_BAD_HI});
		end
		$display("test health verdict done");
		for (int i = 0; i < 4; i++) begin
			s = 8'($urandom) | 8'h01;
			cmd(subs[i], STL_SIG_LO ^ s, s, 8'h80, {2'b11, STL_SIG_LO ^ s, s});
		end
		cmd(8'h00, STL_SIG_LO, STL_SIG_HI, 8'h80, 18'h10000);
		$display("test refusals done");
		spare_thr_i = 8'($urandom);
		erase_thr_i = 8'($urandom);
		s = 8'h00;
		foreach (sec[i])
			sec[i] = 8'h00;
		sec[0] = STL_THR_VER_LO;
		for (int i = 0; i < STL_NUM_IDS; i++)
			sec[2 + 12 * i] = STL_IDS[i];
		sec[3] = spare_thr_i;
		sec[27] = erase_thr_i;
		foreach (sec[i])
			s = s - sec[i];
		sec[511] = s;
		send(STL_SUB_RD_THR, 8'h00);
		$display("test threshold sector done");
		foreach (sec[i])
			sec[i] = (i >= 256 && i < 320 && i % 2 == 0) ? 8'h10 : 8'h00;
		sec[0] = 8'h01;
		sec[10] = 8'h01;
		sec[320] = 8'h04;
		sec[322] = 8'h01;
		sec[324] = 8'h01;
		send(STL_SUB_RD_LOG, STL_LOG_DIR);
		foreach (sec[i])
			sec[i] = 8'h00;
		for (int i = 0; i < 5; i++)
			send(STL_SUB_RD_LOG, 8'(40'h809fa0a1a2 >> (8 * i)));
		for (int i = 0; i < 3; i++)
			cmd(STL_SUB_RD_LOG, STL_SIG_LO, STL_SIG_HI, 8'(24'h017fa3 >> (8 * i)), 18'h10000);
		$display("test logs done");
		for (int i = 0; i < 2; i++) begin
			wlog = i ? 8'h9f : 8'h80;
			widx = 10'h000;
			wr_go <= 1'b1;
			cmd(STL_SUB_WR_LOG, STL_SIG_LO, STL_SIG_HI, wlog, 18'h0);
			wr_go <= 1'b0;
			@(negedge core_clk_i);
			chk("bytes stored", 25'h200, 25'(widx));
			chk("write window", 25'h0, 25'(wr_ready_o));
		end
		for (int i = 0; i < 2; i++)
			cmd(STL_SUB_WR_LOG, STL_SIG_LO, STL_SIG_HI, i ? 8'ha0 : 8'h7f, 18'h10000);
		@(negedge core_clk_i);
		chk("notes left", 25'h0, 25'(st_q.size()));
		$display("test log writes done");
		print_verdict;
	end
endmodule
